// file: rtl/mem_clock_security.v
//Contract
//- loaded flag sets on first divider write
//- ratio bits writable once after reset
//- program and erase refused until loaded
//- bit 6 prescales input by eight
//- divide by ratio field plus one
//- timing pulse is one memory clock
//- option byte copied into options at reset
//- options unused bits zero, writes ignored
//- key enable gates backdoor unlock
//- debug key writes never unlock
//- bit 6 disables vector redirection
//- only code 1:0 means unsecured
//- secured blocks unsecured memory accesses
//- key match or blank check unsecures
//- blocked writes ignored, reads zero
//
// Design decisions made here: the Avalon-MM register port and the address map.
`include "mem_clock_defs.vh"
module mem_clock_security (
   input wire ref_clk_in,
   input wire rst_n_in,
   // avalon-mm slave
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   input wire avs_debug_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   // nonvolatile contents
   input wire [7:0] stored_option_byte_in,
   input wire [63:0] stored_unlock_key_in,
   // program/erase sequencer side
   input wire op_request_in,
   input wire blank_check_pass_in,
   output wire op_enable_out,
   output wire op_refused_out,
   output wire mem_clock_tick_out,
   // security gate for memory accesses
   input wire mem_access_in,
   input wire mem_source_secure_in,
   input wire mem_write_in,
   input wire [7:0] mem_rdata_in,
   output wire mem_write_allow_out,
   output wire [7:0] mem_rdata_out,
   output wire secured_out,
   output wire redirect_enable_out,
   output wire backdoor_enable_out
);
   reg loaded_q;
   reg prescale_q;
   reg [5:0] ratio_q;
   reg [7:0] options_q;
   reg key_acc_q;
   reg [3:0] key_idx_q;
   reg key_ok_q;
   reg unsecured_q;
   reg ack_q;
   reg [31:0] rdata_d;
   wire access;
   wire wr;
   wire [1:0] sec_code;

   // one wait state: every access is answered on its second cycle
   assign access = (avs_read_in | avs_write_in) & ~ack_q;
   assign avs_waitrequest_out = access;
   // writes commit only at the edge where waitrequest is seen low
   assign wr = avs_write_in & ack_q & avs_byteenable_in[0];

   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   // divider register: single accepted write held until reset
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         loaded_q <= 1'b0;
         prescale_q <= 1'b0;
         ratio_q <= 6'h00;
      end else if (wr && avs_address_in == `ADDR_DIVIDER && !loaded_q) begin
         loaded_q <= 1'b1;
         prescale_q <= avs_writedata_in[`DIV_PRESCALE_BIT];
         ratio_q <= avs_writedata_in[`DIV_RATIO_HI:0];
      end
   end

   // option byte copied while reset is held, so it is valid at release
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         options_q <= stored_option_byte_in & `OPT_USED_MASK;
      end
   end

   // key control; debug-sourced writes can set key mode too, but their key bytes never unlock
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         key_acc_q <= 1'b0;
      end else if (wr && avs_address_in == `ADDR_KEY_CTRL) begin
         key_acc_q <= avs_writedata_in[`KEY_ACC_BIT];
      end
   end

   // per-byte key comparison, one lane per stored key byte
   wire [7:0] byte_hit;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : key_lane
         assign byte_hit[g] = (avs_writedata_in[7:0] == stored_unlock_key_in[g*8 +: 8]);
      end
   endgenerate

   // key bytes compared in order against the stored key
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         key_idx_q <= 4'h0;
         key_ok_q <= 1'b1;
         unsecured_q <= 1'b0;
      end else begin
         if (wr && avs_address_in == `ADDR_KEY_DATA && key_acc_q
             && key_idx_q != `KEY_BYTES) begin
            key_idx_q <= key_idx_q + 4'h1;
            if (avs_debug_in
                || !byte_hit[key_idx_q[2:0]]) begin
               key_ok_q <= 1'b0;
            end
         end
         // comparison fires when key access is cleared
         if (wr && avs_address_in == `ADDR_KEY_CTRL && key_acc_q
             && !avs_writedata_in[`KEY_ACC_BIT]) begin
            key_idx_q <= 4'h0;
            key_ok_q <= 1'b1;
            if (options_q[`OPT_KEY_EN_BIT] && key_ok_q && !avs_debug_in
                && key_idx_q == `KEY_BYTES) begin
               unsecured_q <= 1'b1;
            end
         end
         if (blank_check_pass_in) begin
            unsecured_q <= 1'b1;
         end
      end
   end

   // working security code forced to 1:0 once unlocked
   assign sec_code = unsecured_q ? `SEC_UNSECURED : options_q[1:0];
   assign secured_out = (sec_code != `SEC_UNSECURED);
   assign redirect_enable_out = ~options_q[`OPT_NORED_BIT];
   assign backdoor_enable_out = options_q[`OPT_KEY_EN_BIT];

   // secure gate: blocked writes dropped, blocked reads zero
   wire blocked = secured_out & mem_access_in & ~mem_source_secure_in;
   assign mem_write_allow_out = mem_access_in & mem_write_in & ~blocked;
   assign mem_rdata_out = blocked ? 8'h00 : mem_rdata_in;

   // program/erase only after the divider is loaded
   assign op_enable_out = loaded_q;
   assign op_refused_out = op_request_in & ~loaded_q;

   // tick is one memory clock period, the unit of every timing pulse
   mem_clock_gen u_gen (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .run_in(loaded_q),
      .prescale_in(prescale_q),
      .ratio_in(ratio_q),
      .tick_out(mem_clock_tick_out)
   );

   // read mux
   always @* begin
      rdata_d = 32'h00000000;
      case (avs_address_in)
         `ADDR_DIVIDER: rdata_d = {24'h000000, loaded_q, prescale_q, ratio_q};
         `ADDR_OPTIONS: rdata_d = {24'h000000, options_q[7:2], sec_code};
         `ADDR_KEY_CTRL: rdata_d = {31'h00000000, key_acc_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h00000000;
      end else if (avs_read_in && !ack_q) begin
         avs_readdata_out <= rdata_d;
      end
   end
endmodule // mem_clock_security

// file: rtl/mem_clock_defs.vh
`ifndef MEM_CLOCK_DEFS_VH
`define MEM_CLOCK_DEFS_VH
// register byte addresses (word aligned)
`define ADDR_DIVIDER 4'h0
`define ADDR_OPTIONS 4'h4
`define ADDR_KEY_CTRL 4'h8
`define ADDR_KEY_DATA 4'hc
// divider register fields
`define DIV_LOADED_BIT 7
`define DIV_PRESCALE_BIT 6
`define DIV_RATIO_HI 5
// options register fields
`define OPT_KEY_EN_BIT 7
`define OPT_NORED_BIT 6
`define OPT_USED_MASK 8'hc3
`define SEC_UNSECURED 2'h2
// key control bit and key length
`define KEY_ACC_BIT 0
`define KEY_BYTES 4'h8
// last prescale count (prescale ratio of eight)
`define PRESCALE_LAST 3'h7
// longest timing pulse in ns, and the 100 MHz clock period in ns
`define PULSE_MAX_NS 6700
`define CLK_PERIOD_NS 10
`define PULSE_MAX_CYC (`PULSE_MAX_NS / `CLK_PERIOD_NS)
`endif

// file: rtl/mem_clock_gen.v
`include "mem_clock_defs.vh"
// divides the bus clock into the memory timing tick
module mem_clock_gen (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire run_in,
   input wire prescale_in,
   input wire [5:0] ratio_in,
   output reg tick_out
);
   reg [2:0] pre_q;
   reg [5:0] cnt_q;
   wire step;

   // step is every bus clock, or every eighth one when prescaled
   assign step = ~prescale_in | (pre_q == `PRESCALE_LAST);

   // prescale counter, free running once enabled
   always @(posedge ref_clk_in) begin
      if (!rst_n_in || !run_in) begin
         pre_q <= 3'h0;
      end else begin
         pre_q <= pre_q + 3'h1;
      end
   end

   // ratio counter: one tick per ratio+1 steps
   always @(posedge ref_clk_in) begin
      if (!rst_n_in || !run_in) begin
         cnt_q <= 6'h00;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (step) begin
            if (cnt_q == ratio_in) begin
               cnt_q <= 6'h00;
               tick_out <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 6'h01;
            end
         end
      end
   end
endmodule // mem_clock_gen

// file: sim/mem_clock_security_properties.sv
module mem_clock_security_properties (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire avs_waitrequest_out,
   input wire op_request_in,
   input wire op_enable_out,
   input wire op_refused_out,
   input wire mem_clock_tick_out,
   input wire mem_access_in,
   input wire mem_source_secure_in,
   input wire [7:0] mem_rdata_out,
   input wire mem_write_allow_out,
   input wire secured_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // an untrusted access while secured
   wire blocked = mem_access_in && secured_out && !mem_source_secure_in;
   sequence req_start;
      $rose(avs_read_in || avs_write_in);
   endsequence
   sequence one_wait;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   chk_wait_one: assert property (req_start |-> one_wait)
      else $error("waitrequest not one cycle");
   chk_refuse_early: assert property (op_request_in && !op_enable_out |-> op_refused_out)
      else $error("request not refused");
   chk_allow_loaded: assert property (op_enable_out |-> !op_refused_out)
      else $error("request refused after load");
   chk_loaded_holds: assert property (op_enable_out |=> op_enable_out)
      else $error("loaded flag dropped");
   chk_tick_idle: assert property (!op_enable_out |-> !mem_clock_tick_out)
      else $error("tick before load");
   chk_block_write: assert property (blocked |-> !mem_write_allow_out)
      else $error("blocked write passed");
   chk_block_read: assert property (blocked |-> mem_rdata_out == 8'h00)
      else $error("blocked read not zero");
   chk_unsecure_holds: assert property (!secured_out |=> !secured_out)
      else $error("security came back");
endmodule // mem_clock_security_properties
bind mem_clock_security mem_clock_security_properties mem_clock_security_properties_inst (.*);

// file: sim/mem_clock_security_tb_top.sv
module mem_clock_security_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, dbg = 0, opr = 0, blank = 0, src = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, opt = 8'hfd, got, mem_out;
   logic [63:0] key = 64'h8877665544332211;
   logic [31:0] rdata;
   logic waitreq, enable, refused, tick, allow, secured, redirect, backdoor;
   int err_count = 0, compares = 0, n;
   always #5 ref_clk_in = ~ref_clk_in;
   mem_clock_security mem_clock_security_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in({24'h000000, wdata}), .avs_byteenable_in(4'hf), .avs_debug_in(dbg),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .stored_option_byte_in(opt), .stored_unlock_key_in(key), .op_request_in(opr),
      .blank_check_pass_in(blank), .op_enable_out(enable), .op_refused_out(refused),
      .mem_clock_tick_out(tick), .mem_access_in(1'b1), .mem_source_secure_in(src),
      .mem_write_in(1'b1), .mem_rdata_in(8'h5a), .mem_write_allow_out(allow),
      .mem_rdata_out(mem_out), .secured_out(secured), .redirect_enable_out(redirect),
      .backdoor_enable_out(backdoor));
   task automatic check(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one bus transfer; held until waitrequest is sampled low at a rising edge
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      rd <= !w; wr <= w; addr <= a; wdata <= d;
      do @(posedge ref_clk_in); while (waitreq !== 1'b0);
      got = rdata[7:0];
      rd <= 0; wr <= 0;
   endtask
   task automatic restart(input logic [7:0] o);
      @(posedge ref_clk_in);
      rst_n_in <= 0; opt <= o;
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1; opr <= 1;
      @(posedge ref_clk_in);
   endtask
   // key access on, eight bytes in order, key access off
   task automatic enter_key(input logic d, input logic [63:0] k);
      xfer(1, 4'h8, 8'h01);
      dbg <= d;
      for (int i = 0; i < 8; i++) xfer(1, 4'hc, k[8*i +: 8]);
      dbg <= 0;
      xfer(1, 4'h8, 8'h00);
      repeat (3) @(negedge ref_clk_in);
   endtask
   // cycles between two ticks
   task automatic period(input int exp);
      @(posedge tick);
      @(negedge ref_clk_in);
      n = 0;
      do begin @(negedge ref_clk_in); n++; end while (tick !== 1'b1);
      check("period", n, exp);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      restart(8'hfd);
      xfer(0, 4'h0, 8'h00); check("divider", got, 8'h00);
      check("refused", refused, 1);
      xfer(1, 4'h4, 8'h00);
      xfer(0, 4'h4, 8'h00); check("options", got, 8'hc1);
      xfer(0, 4'h2, 8'h00); check("unmapped", got, 8'h00);
      check("redirect", redirect, 0);
      check("backdoor", backdoor, 1);
      check("secured", secured, 1);
      check("mem read", mem_out, 8'h00);
      check("mem write", allow, 0);
      src <= 1;
      @(posedge ref_clk_in);
      check("mem read", mem_out, 8'h5a);
      check("mem write", allow, 1);
      src <= 0;
      xfer(1, 4'h0, 8'h7e);
      xfer(1, 4'h0, 8'h45);
      xfer(0, 4'h0, 8'h00); check("divider", got, 8'hfe);
      check("enable", enable, 1);
      check("refused", refused, 0);
      period(504);
      enter_key(1, key); check("secured", secured, 1);
      enter_key(0, key ^ 64'h1); check("secured", secured, 1);
      enter_key(0, key); check("secured", secured, 0);
      xfer(0, 4'h4, 8'h00); check("options", got, 8'hc2);
      check("mem read", mem_out, 8'h5a);
      check("mem write", allow, 1);
      restart(8'h3c);
      xfer(0, 4'h4, 8'h00); check("options", got, 8'h00);
      check("redirect", redirect, 1);
      xfer(1, 4'h0, 8'h7f);
      period(512);
      enter_key(0, key); check("secured", secured, 1);
      @(posedge ref_clk_in) blank <= 1;
      @(posedge ref_clk_in) blank <= 0;
      repeat (2) @(negedge ref_clk_in);
      check("secured", secured, 0);
      print_verdict();
   end
   // hang guard, well beyond the few thousand cycles the tests need
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule // mem_clock_security_tb_top
